// ---- src/isk_exec.sv ----
/*
  isk_exec: execution of increment-skip-if-zero and increment-skip-if-
  nonzero on a four-phase instruction cycle, including operand address
  forming (access bank, bank select, indexed literal offset).
  Assumes the fetch unit holds instr_word stable through phase 0, the
  data memory answers file_rdata in the same phase file_rd is high, and
  next_two_word describes the prefetched word when phase 3 ends.
*/
// What this block does
// RULE1: increment file; d picks accumulator or file
// RULE2: skip-if-zero skips when result is zero
// RULE3: skip discards prefetched word, runs no-op
// RULE4: one cycle normally, two when skipping
// RULE5: skipped two-word instruction costs three cycles
// RULE6: a=0 resolves operand in access bank
// RULE7: a=1 uses bank select register
// RULE8: a=0, extended set, f<=95: literal offset
// RULE9: skip-if-nonzero writes, skips on nonzero result
// RULE10: decode, read, compute, write in phases
// RULE11: decode opcodes 001111 and 010010, then d,a,f
// RULE12: no arithmetic status flag is changed
`timescale 1ns/100ps
module isk_exec
  import isk_pkg::*;
(
  // clock and reset
  input  wire logic              clk,
  input  wire logic              rst_n,
  // instruction from fetch
  input  wire logic [ISK_IW-1:0] instr_word,
  input  wire logic              instr_valid,
  input  wire logic              next_two_word,
  // addressing context
  input  wire logic              ext_set_en,
  input  wire logic [3:0]        bank_select_register,
  input  wire logic [ISK_AW-1:0] index_base,
  // data memory
  output logic [ISK_AW-1:0]      file_addr,
  output logic                   file_rd,
  input  wire logic [ISK_DW-1:0] file_rdata,
  output logic                   file_we,
  output logic [ISK_DW-1:0]      file_wdata,
  // accumulator
  output logic                   acc_we,
  output logic [ISK_DW-1:0]      acc_wdata,
  // core sequencing
  output logic [1:0]             phase,
  output logic                   nop_cycle,
  output logic                   discard_fetch,
  output logic                   status_we
);
  isk_st_e           st_ff,    nxt_st;
  isk_op_e           op_ff,    nxt_op;
  logic [1:0]        phase_ff, nxt_phase;
  logic              dest_ff,  nxt_dest;
  logic              bank_ff,  nxt_bank;
  logic [7:0]        f_ff,     nxt_f;
  logic [ISK_AW-1:0] addr_ff,  nxt_addr;
  logic [7:0]        data_ff,  nxt_data;
  logic [7:0]        sum_ff,   nxt_sum;
  logic              fwe_ff,   nxt_fwe;
  logic              awe_ff,   nxt_awe;
  logic              two_ff,   nxt_two;
  logic              disc_ff,  nxt_disc;
  logic              skip_now;
  logic [5:0]        opc;
  logic [7:0]        f_in;

  assign opc  = instr_word[ISK_OPC_MSB:ISK_OPC_LSB];
  assign f_in = instr_word[ISK_F_MSB:0];
  // result zero drives both skip senses from one comparator
  assign skip_now = (st_ff == ISK_ST_EXEC) && (phase_ff == ISK_PH_WRITE) &&
                    (((op_ff == ISK_OP_INZ) && (sum_ff == ISK_ZERO)) ||     // RULE2
                     ((op_ff == ISK_OP_INN) && (sum_ff != ISK_ZERO)));      // RULE9

  always_comb begin
    nxt_phase = phase_ff + 2'h1;
    nxt_st    = st_ff;
    nxt_op    = op_ff;
    nxt_dest  = dest_ff;
    nxt_bank  = bank_ff;
    nxt_f     = f_ff;
    nxt_addr  = addr_ff;
    nxt_data  = data_ff;
    nxt_sum   = sum_ff;
    nxt_fwe   = 1'b0;
    nxt_awe   = 1'b0;
    nxt_two   = two_ff;
    nxt_disc  = 1'b0;
    case (phase_ff)
      ISK_PH_DECODE: begin // RULE10
        nxt_op = ISK_OP_NONE;
        if ((st_ff == ISK_ST_EXEC) && instr_valid) begin
          if (opc == ISK_OPC_INZ) begin // RULE11
            nxt_op = ISK_OP_INZ;
          end else if (opc == ISK_OPC_INN) begin // RULE11
            nxt_op = ISK_OP_INN;
          end
        end
        nxt_dest = instr_word[ISK_DEST_BIT];
        nxt_bank = instr_word[ISK_BANK_BIT];
        nxt_f    = f_in;
        if (instr_word[ISK_BANK_BIT]) begin
          nxt_addr = {bank_select_register, f_in}; // RULE7
        end else if (ext_set_en && (f_in <= ISK_LIT_MAX)) begin
          nxt_addr = index_base + {4'h0, f_in}; // RULE8
        end else if (f_in < ISK_ACC_SPLIT) begin
          nxt_addr = {ISK_ACC_LO_BANK, f_in}; // RULE6
        end else begin
          nxt_addr = {ISK_ACC_HI_BANK, f_in}; // RULE6
        end
      end
      ISK_PH_READ: begin
        nxt_data = file_rdata; // RULE10
      end
      ISK_PH_PROC: begin
        nxt_sum = data_ff + ISK_ONE; // RULE1
        if ((st_ff == ISK_ST_EXEC) && (op_ff != ISK_OP_NONE)) begin
          nxt_fwe = dest_ff;  // RULE1
          nxt_awe = !dest_ff; // RULE1
        end
      end
      ISK_PH_WRITE: begin
        case (st_ff)
          ISK_ST_EXEC: begin
            if (skip_now) begin
              nxt_st   = ISK_ST_NOP1; // RULE3
              nxt_two  = next_two_word;
              nxt_disc = 1'b1; // RULE3
            end
          end
          ISK_ST_NOP1: begin
            nxt_st = two_ff ? ISK_ST_NOP2 : ISK_ST_EXEC; // RULE4 RULE5
          end
          ISK_ST_NOP2: begin
            nxt_st = ISK_ST_EXEC; // RULE5
          end
          default: begin
            nxt_st = ISK_ST_EXEC;
          end
        endcase
      end
      default: begin
        nxt_phase = ISK_PH_RST;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      st_ff    <= ISK_ST_EXEC;
      op_ff    <= ISK_OP_NONE;
      phase_ff <= ISK_PH_RST;
      dest_ff  <= 1'b0;
      bank_ff  <= 1'b0;
      f_ff     <= ISK_ZERO;
      addr_ff  <= '0;
      data_ff  <= ISK_ZERO;
      sum_ff   <= ISK_ZERO;
      fwe_ff   <= 1'b0;
      awe_ff   <= 1'b0;
      two_ff   <= 1'b0;
      disc_ff  <= 1'b0;
    end else begin
      st_ff    <= nxt_st;
      op_ff    <= nxt_op;
      phase_ff <= nxt_phase;
      dest_ff  <= nxt_dest;
      bank_ff  <= nxt_bank;
      f_ff     <= nxt_f;
      addr_ff  <= nxt_addr;
      data_ff  <= nxt_data;
      sum_ff   <= nxt_sum;
      fwe_ff   <= nxt_fwe;
      awe_ff   <= nxt_awe;
      two_ff   <= nxt_two;
      disc_ff  <= nxt_disc;
    end
  end

  assign phase         = phase_ff;
  assign file_addr     = addr_ff;
  assign file_rd       = (st_ff == ISK_ST_EXEC) && (op_ff != ISK_OP_NONE) &&
                         (phase_ff == ISK_PH_READ); // RULE10
  assign file_we       = fwe_ff;
  assign acc_we        = awe_ff;
  assign file_wdata    = sum_ff;
  assign acc_wdata     = sum_ff;
  assign nop_cycle     = (st_ff != ISK_ST_EXEC); // RULE3
  assign discard_fetch = disc_ff;
  // flags untouched, so the flag unit never sees a write from here
  assign status_we     = 1'b0; // RULE12

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  wr_dest_a: assert property ( // RULE1
    (st_ff == ISK_ST_EXEC && op_ff != ISK_OP_NONE && phase_ff == ISK_PH_PROC)
      |=> (file_we == $past(dest_ff)) && (acc_we == !$past(dest_ff)))
    else $error("destination write enable wrong");
  wr_data_a: assert property ( // RULE1
    (file_we || acc_we) |-> (file_wdata == $past(file_rdata, 2) + ISK_ONE))
    else $error("written value is not read value plus one");
  skip_zero_a: assert property ( // RULE2
    (phase_ff == ISK_PH_WRITE && st_ff == ISK_ST_EXEC && op_ff == ISK_OP_INZ && sum_ff == ISK_ZERO)
      |=> nop_cycle[*4])
    else $error("zero result did not skip");
  nop_quiet_a: assert property ( // RULE3
    nop_cycle |-> !file_rd && !file_we && !acc_we)
    else $error("substituted no-op touched memory");
  no_skip_a: assert property ( // RULE4
    (phase_ff == ISK_PH_WRITE && st_ff == ISK_ST_EXEC && !skip_now) |=> !nop_cycle)
    else $error("no-op inserted without skip");
  skip_one_a: assert property ( // RULE4
    (skip_now && !next_two_word) |=> nop_cycle[*4] ##1 !nop_cycle)
    else $error("one-word skip length wrong");
  skip_two_a: assert property ( // RULE5
    (skip_now && next_two_word) |=> nop_cycle[*8] ##1 !nop_cycle)
    else $error("two-word skip length wrong");
  acc_bank_a: assert property ( // RULE6
    (file_rd && !bank_ff && !($past(ext_set_en) && f_ff <= ISK_LIT_MAX))
      |-> file_addr == {(f_ff < ISK_ACC_SPLIT) ? ISK_ACC_LO_BANK : ISK_ACC_HI_BANK, f_ff})
    else $error("access bank address wrong");
  bsr_addr_a: assert property ( // RULE7
    (file_rd && bank_ff) |-> file_addr == {$past(bank_select_register), f_ff})
    else $error("banked address wrong");
  lit_off_a: assert property ( // RULE8
    (file_rd && !bank_ff && $past(ext_set_en) && f_ff <= ISK_LIT_MAX)
      |-> file_addr == $past(index_base) + {4'h0, f_ff})
    else $error("literal offset address wrong");
  skip_nz_a: assert property ( // RULE9
    (phase_ff == ISK_PH_WRITE && st_ff == ISK_ST_EXEC && op_ff == ISK_OP_INN)
      |=> (nop_cycle == ($past(sum_ff) != ISK_ZERO)) && (discard_fetch == nop_cycle))
    else $error("nonzero skip decision wrong");
  read_phase_a: assert property ( // RULE10
    file_rd |-> phase_ff == ISK_PH_READ ##2 (phase_ff == ISK_PH_WRITE))
    else $error("read outside its phase");

  skip_zero_c: cover property (skip_now && op_ff == ISK_OP_INZ);
  skip_two_c: cover property (skip_now && next_two_word);
  no_skip_c: cover property (phase_ff == ISK_PH_WRITE && op_ff == ISK_OP_INN && !skip_now);
endmodule : isk_exec

// ---- src/isk_pkg.sv ----
/*
  isk_pkg: opcodes, instruction fields, phase codes and addressing
  constants for the increment-and-skip execution block.
  Assumes 16-bit program words and 12-bit data-memory addresses.
*/
package isk_pkg;
  localparam int unsigned ISK_IW          = 16;
  localparam int unsigned ISK_AW          = 12;
  localparam int unsigned ISK_DW          = 8;
  // upper six bits of the two opcodes
  localparam logic [5:0]  ISK_OPC_INZ     = 6'h0f;
  localparam logic [5:0]  ISK_OPC_INN     = 6'h12;
  // field positions inside the instruction word
  localparam int unsigned ISK_OPC_MSB     = 15;
  localparam int unsigned ISK_OPC_LSB     = 10;
  localparam int unsigned ISK_DEST_BIT    = 9;
  localparam int unsigned ISK_BANK_BIT    = 8;
  localparam int unsigned ISK_F_MSB       = 7;
  // phases of one instruction cycle
  localparam logic [1:0]  ISK_PH_DECODE   = 2'h0;
  localparam logic [1:0]  ISK_PH_READ     = 2'h1;
  localparam logic [1:0]  ISK_PH_PROC     = 2'h2;
  localparam logic [1:0]  ISK_PH_WRITE    = 2'h3;
  // access bank split and literal-offset window
  localparam logic [7:0]  ISK_ACC_SPLIT   = 8'h80;
  localparam logic [7:0]  ISK_LIT_MAX     = 8'h5f;
  localparam logic [3:0]  ISK_ACC_LO_BANK = 4'h0;
  localparam logic [3:0]  ISK_ACC_HI_BANK = 4'hf;
  localparam logic [7:0]  ISK_ONE         = 8'h01;
  localparam logic [7:0]  ISK_ZERO        = 8'h00;
  localparam logic [1:0]  ISK_PH_RST      = 2'h0;

  typedef enum logic [1:0] {ISK_OP_NONE, ISK_OP_INZ, ISK_OP_INN} isk_op_e;
  typedef enum logic [1:0] {ISK_ST_EXEC, ISK_ST_NOP1, ISK_ST_NOP2} isk_st_e;
endpackage : isk_pkg

// ---- verif/increment_skip_execution_test.sv ----
/*
  increment_skip_execution_test: self-checking bench for isk_exec.
  Assumes isk_pkg and isk_exec are compiled first; the bench plays both
  fetch unit and data memory, so no separate partner model is used.
*/
`timescale 1ns/100ps
module increment_skip_execution_test
  import isk_pkg::*;
;
  logic              clk;
  logic              rst_n;
  logic [ISK_IW-1:0] instr_word;
  logic              instr_valid;
  logic              next_two_word;
  logic              ext_set_en;
  logic [3:0]        bank;
  logic [ISK_AW-1:0] index_base;
  logic [ISK_AW-1:0] file_addr;
  logic              file_rd;
  logic [ISK_DW-1:0] file_rdata;
  logic              file_we;
  logic [ISK_DW-1:0] file_wdata;
  logic              acc_we;
  logic [ISK_DW-1:0] acc_wdata;
  logic [1:0]        phase;
  logic              nop_cycle;
  logic              discard_fetch;
  logic              status_we;
  int                mismatches;
  int                total_checks;
  logic [29:0]       exp_q[$];
  logic [31:0]       seed = 32'h0000eb75;
  logic [31:0]       r;

  isk_exec i_isk_exec (.clk(clk), .rst_n(rst_n), .instr_word(instr_word), .instr_valid(instr_valid),
    .next_two_word(next_two_word), .ext_set_en(ext_set_en), .bank_select_register(bank),
    .index_base(index_base), .file_addr(file_addr), .file_rd(file_rd), .file_rdata(file_rdata),
    .file_we(file_we), .file_wdata(file_wdata), .acc_we(acc_we), .acc_wdata(acc_wdata),
    .phase(phase), .nop_cycle(nop_cycle), .discard_fetch(discard_fetch), .status_we(status_we));

  task automatic results();
    if (mismatches == 0 && total_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : results

  task automatic cmp_write(input logic [29:0] got, input logic [29:0] exp);
    total_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : cmp_write

  task automatic cmp_flag(input logic got, input logic exp);
    cmp_write({29'h0, got}, {29'h0, exp});
  endtask : cmp_flag

  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : xs

  function automatic logic [11:0] exp_addr(logic a, logic ext, logic [3:0] b, logic [11:0] base, logic [7:0] f);
    if (a) return {b, f};
    if (ext && f <= ISK_LIT_MAX) return base + {4'h0, f};
    return {(f < ISK_ACC_SPLIT) ? ISK_ACC_LO_BANK : ISK_ACC_HI_BANK, f};
  endfunction : exp_addr

  // present one instruction at phase 0 start and note its write
  task automatic exec(input logic [15:0] w, input logic v, input logic [7:0] rd, input logic tw,
                      input logic ext, input logic [3:0] b, input logic [11:0] base);
    logic [7:0] res;
    logic       hit;
    logic       skip;
    res = rd + 8'h01;
    hit = v && (w[15:10] === ISK_OPC_INZ || w[15:10] === ISK_OPC_INN);
    skip = hit && ((w[15:10] === ISK_OPC_INZ) == (res === 8'h00));
    @(posedge clk);
    while (phase !== 2'h3) @(posedge clk);
    instr_word <= w;
    instr_valid <= v;
    file_rdata <= rd;
    next_two_word <= tw;
    ext_set_en <= ext;
    bank <= b;
    index_base <= base;
    if (hit) exp_q.push_back({w[9], !w[9], exp_addr(w[8], ext, b, base, w[7:0]), res, res});
    repeat (2) @(posedge clk);
    cmp_flag(file_rd, hit);
    @(posedge clk);
    if (skip) begin
      @(posedge clk);
      // offered during the no-op, must be ignored
      instr_word <= {ISK_OPC_INZ, 10'h0};
      @(posedge clk);
      cmp_flag(discard_fetch, 1'b1);
      cmp_flag(nop_cycle, 1'b1);
      repeat (tw ? 7 : 3) @(posedge clk);
      cmp_flag(nop_cycle, 1'b1);
      instr_valid <= 1'b0;
      @(posedge clk);
      cmp_flag(nop_cycle, 1'b0);
      cmp_flag(discard_fetch, 1'b0);
      repeat (2) @(posedge clk);
    end
  endtask : exec

  always @(posedge clk) begin
    if (rst_n === 1'b1) begin
      cmp_flag(status_we, 1'b0);
      if (file_rd === 1'b1) cmp_flag(phase === ISK_PH_READ, 1'b1);
      if (file_we === 1'b1 || acc_we === 1'b1) begin
        cmp_flag(phase === ISK_PH_WRITE, 1'b1);
        cmp_write({file_we, acc_we, file_addr, file_wdata, acc_wdata},
                  exp_q.size() ? exp_q.pop_front() : 30'h3fffffff);
      end
    end
  end

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  initial begin
    #(4 * 6000);
    mismatches++;
    results();
  end

  initial begin
    rst_n = 1'b0;
    instr_word = '0;
    instr_valid = 1'b0;
    next_two_word = 1'b0;
    ext_set_en = 1'b0;
    bank = 4'h0;
    index_base = '0;
    file_rdata = '0;
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    exec({ISK_OPC_INZ, 2'b10, 8'h5f}, 1'b1, 8'hff, 1'b1, 1'b1, 4'h3, 12'hffa);
    exec({ISK_OPC_INN, 2'b00, 8'h60}, 1'b1, 8'h10, 1'b0, 1'b1, 4'h3, 12'h100);
    exec({ISK_OPC_INN, 2'b01, 8'h80}, 1'b1, 8'hff, 1'b0, 1'b0, 4'h5, 12'h000);
    exec({ISK_OPC_INZ, 2'b00, 8'h81}, 1'b1, 8'h41, 1'b0, 1'b1, 4'h2, 12'h000);
    exec({6'h0a, 2'b10, 8'h12}, 1'b1, 8'h00, 1'b0, 1'b0, 4'h0, 12'h000);
    exec({ISK_OPC_INZ, 2'b10, 8'h12}, 1'b0, 8'hff, 1'b0, 1'b0, 4'h0, 12'h000);
    // back-to-back random mix, biased towards zero results and the 0x5f edge
    for (int i = 0; i < 80; i++) begin
      r = xs();
      exec({(r[1:0] == 2'h3) ? r[15:10] : (r[0] ? ISK_OPC_INN : ISK_OPC_INZ), r[9:8],
            r[20] ? 8'h5f + {7'h0, r[21]} : r[31:24]}, r[4] | r[5], (r[3:2] == 2'h0) ? 8'hff : r[23:16],
           r[6], r[7], r[11:8], r[31:20]);
    end
    exec(16'h0000, 1'b0, 8'h00, 1'b0, 1'b0, 4'h0, 12'h000);
    repeat (8) @(posedge clk);
    cmp_write(30'(exp_q.size()), 30'h0);
    results();
  end
endmodule : increment_skip_execution_test
